// *** analog_enable_and_mode_regs.v ***
/*
 * Analog block enable and role select registers of a power-converter
 * controller, with the routing they steer: error amplifier control, gate
 * drive lockout level, test output pin mux and master/slave pin routing.
 * Assumes a classic Wishbone master, one 250 MHz clock, synchronous
 * active-high reset and all inputs synchronous to the clock.
 */
// The Wishbone slave port and the address map were chosen for this implementation.
`default_nettype none
`include "analog_mode_consts.vh"

module analog_enable_and_mode_regs #(
    parameter ADDR_W     = 8,
    parameter PULSE_CNTW = 8
) (
    // Clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // Wishbone slave
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [ADDR_W-1:0]    wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    // Internal digital test sources
    input  wire                 desaturation_comparator_out_i,
    input  wire                 pwm_after_mono_i,
    input  wire                 pwm_osc_i,
    input  wire                 timer_period_match_i,
    input  wire                 overvoltage_comparator_out_i,
    input  wire                 internal_switching_clock_i,
    input  wire                 secondary_drive_on_i,
    // General-purpose port values for the shared pins
    input  wire                 gp_ref_out_i,
    input  wire                 gp_sync_out_i,
    input  wire                 gp_sync_oe_n_i,
    // Analog control
    output reg                  driver_lockout_level_select_o,
    output reg                  current_amp_disable_o,
    output reg                  voltage_amp_disable_o,
    output reg                  current_amp_in_loop_o,
    output reg                  voltage_amp_in_loop_o,
    output reg                  amp_outputs_pull_low_o,
    output reg                  ov_protect_enable_o,
    output reg                  secondary_drive_pulse_o,
    // Test output pin
    output reg                  test_output_pin_o,
    output reg                  test_output_pin_oe_n_o,
    output reg                  test_pin_analog_connect_o,
    output reg                  analog_to_converter_o,
    // Reference output pin
    output reg                  reference_output_pin_o,
    output reg                  reference_pin_analog_connect_o,
    // Sync pin
    input  wire                 sync_pin_i,
    output reg                  sync_pin_o,
    output reg                  sync_pin_oe_n_o,
    output reg                  switching_clock_o
);

    reg  [7:0] analog_block_enable;
    reg  [7:0] role_select;
    reg        next_test_value;
    reg        next_ref_analog;
    reg        next_ref_value;
    reg        next_sync_value;
    reg        next_sync_oe_n;
    reg        next_switching_clock;
    wire       secondary_pulse;
    wire       bus_req;
    wire       wr_lane0;
    wire       wr_abe;
    wire       wr_role;
    reg  [7:0] read_byte;

    wire       digital_test_connect = analog_block_enable[`ABE_DIG_CONNECT];
    wire [2:0] digital_test_select  = analog_block_enable[`ABE_DSEL_HI:`ABE_DSEL_LO];
    wire       analog_test_connect  = analog_block_enable[`ABE_ANA_CONNECT];
    wire       current_amp_disable  = analog_block_enable[`ABE_CAMP_DIS];
    wire       voltage_amp_disable  = analog_block_enable[`ABE_VAMP_DIS];
    wire [1:0] role_field           = role_select[`ROLE_FIELD_HI:`ROLE_FIELD_LO];
    wire       semi_master_option   = role_select[`ROLE_SEMI_OPT];

    // The one-shot also feeds secondary_drive_pulse_o, not only the mux.
    pulse_stretcher #(
        .WIDTH (`SEC_PULSE_CYCLES),
        .CNT_W (PULSE_CNTW)
    ) u_secondary_pulse (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .trigger_i (secondary_drive_on_i),
        .pulse_o   (secondary_pulse)
    );

    // Register access. Ack comes one cycle after the request and drops the
    // cycle after, so back-to-back strobes see a one-cycle gap.
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_abe   = wr_lane0 && (wb_adr_i == `ABE_OFFSET);
    assign wr_role  = wr_lane0 && (wb_adr_i == `ROLE_OFFSET);

    // Unmapped offsets read as zero so software can probe the map safely.
    always @*
    begin
        case (wb_adr_i)
            `ABE_OFFSET:  read_byte = analog_block_enable;
            `ROLE_OFFSET: read_byte = role_select;
            default:      read_byte = 8'h00;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            analog_block_enable <= `ABE_RESET;
            role_select         <= `ROLE_RESET;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= {24'h000000, read_byte};
            end
            if (wr_abe)
            begin
                analog_block_enable <= wb_dat_i[7:0];
            end
            if (wr_role)
            begin
                role_select <= wb_dat_i[7:0] & `ROLE_WRITE_MASK;
            end
        end
    end

    // Switching clock source: the sync pin in the slave role, else the internal clock.
    always @*
    begin
        if (role_field == `ROLE_SLAVE)
        begin
            next_switching_clock = sync_pin_i;
        end
        else
        begin
            next_switching_clock = internal_switching_clock_i;
        end
    end

    // Digital test mux. The unused code gives a quiet low level.
    always @*
    begin
        case (digital_test_select)
            `DSEL_DESAT:       next_test_value = desaturation_comparator_out_i;
            `DSEL_PWM_MONO:    next_test_value = pwm_after_mono_i;
            `DSEL_PWM_OSC:     next_test_value = pwm_osc_i;
            `DSEL_TIMER_MATCH: next_test_value = timer_period_match_i;
            `DSEL_OVERVOLT:    next_test_value = overvoltage_comparator_out_i;
            `DSEL_SW_FREQ:     next_test_value = next_switching_clock;
            `DSEL_SEC_PULSE:   next_test_value = secondary_pulse;
            default:           next_test_value = 1'b0;
        endcase
    end

    // Pin routing by role. In slave mode the sync pin is an input, so it is
    // released; outside any role use the pins fall back to their port values.
    always @*
    begin
        next_ref_analog = 1'b0;
        next_ref_value  = gp_ref_out_i;
        next_sync_value = gp_sync_out_i;
        next_sync_oe_n  = gp_sync_oe_n_i;
        case (role_field)
            `ROLE_STANDALONE:
            begin
                next_ref_analog = 1'b0;
            end
            `ROLE_MASTER:
            begin
                next_ref_analog = 1'b1;
                next_sync_value = internal_switching_clock_i;
                next_sync_oe_n  = 1'b0;
            end
            `ROLE_SLAVE:
            begin
                next_sync_oe_n = 1'b1;
            end
            `ROLE_SEMI_MASTER:
            begin
                if (semi_master_option)
                begin
                    next_sync_value = internal_switching_clock_i;
                    next_sync_oe_n  = 1'b0;
                end
                else
                begin
                    next_ref_analog = 1'b1;
                end
            end
            default:
            begin
                next_ref_analog = 1'b0;
            end
        endcase
    end

    // All outputs are registered, so they follow a register write by one cycle.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            driver_lockout_level_select_o  <= 1'b0;
            current_amp_disable_o          <= 1'b0;
            voltage_amp_disable_o          <= 1'b0;
            current_amp_in_loop_o          <= 1'b1;
            voltage_amp_in_loop_o          <= 1'b1;
            amp_outputs_pull_low_o         <= 1'b0;
            ov_protect_enable_o            <= 1'b0;
            secondary_drive_pulse_o        <= 1'b0;
        end
        else
        begin
            // Low selects the 2.7V lockout, high the 5.4V lockout.
            driver_lockout_level_select_o <= analog_block_enable[`ABE_LOCKOUT_SEL];
            current_amp_disable_o <= current_amp_disable;
            voltage_amp_disable_o <= voltage_amp_disable;
            // A disabled amp only tracks the other one; with both off, no demand.
            current_amp_in_loop_o  <= !current_amp_disable;
            voltage_amp_in_loop_o  <= !voltage_amp_disable;
            amp_outputs_pull_low_o <= current_amp_disable && voltage_amp_disable;
            ov_protect_enable_o    <= voltage_amp_disable;
            secondary_drive_pulse_o <= secondary_pulse;
        end
    end

    // Test output pin. Reset leaves it released and analog on the converter.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            test_output_pin_o              <= 1'b0;
            test_output_pin_oe_n_o         <= 1'b1;
            test_pin_analog_connect_o      <= 1'b0;
            analog_to_converter_o          <= 1'b1;
        end
        else
        begin
            // Digital connection wins; the analog buffer then stays off the pin.
            test_output_pin_o         <= digital_test_connect && next_test_value;
            test_output_pin_oe_n_o    <= !digital_test_connect;
            test_pin_analog_connect_o <= analog_test_connect && !digital_test_connect;
            analog_to_converter_o     <= !analog_test_connect;
        end
    end

    // Shared reference and sync pins. Reset releases the sync pin, so a
    // partner already driving it never fights the device during start-up.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reference_output_pin_o         <= 1'b0;
            reference_pin_analog_connect_o <= 1'b0;
            sync_pin_o                     <= 1'b0;
            sync_pin_oe_n_o                <= 1'b1;
            switching_clock_o              <= 1'b0;
        end
        else
        begin
            reference_output_pin_o         <= next_ref_analog ? 1'b0 : next_ref_value;
            reference_pin_analog_connect_o <= next_ref_analog;
            sync_pin_o        <= next_sync_value;
            sync_pin_oe_n_o   <= next_sync_oe_n;
            switching_clock_o <= next_switching_clock;
        end
    end

endmodule // analog_enable_and_mode_regs

`default_nettype wire

// *** analog_mode_consts.vh ***
/*
 * Offsets, field positions, reset values and timing counts for the analog
 * enable and role select register bank.
 * Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
 */
`ifndef ANALOG_MODE_CONSTS_VH
`define ANALOG_MODE_CONSTS_VH

// Register byte offsets, one aligned word each.
`define ABE_OFFSET          8'h00
`define ROLE_OFFSET         8'h04

// Analog block enable register fields.
`define ABE_RESET           8'h00
`define ABE_DIG_CONNECT     7
`define ABE_DSEL_HI         6
`define ABE_DSEL_LO         4
`define ABE_LOCKOUT_SEL     3
`define ABE_VAMP_DIS        2
`define ABE_CAMP_DIS        1
`define ABE_ANA_CONNECT     0

// Role select register fields; all other bits are unimplemented.
`define ROLE_RESET          8'h00
`define ROLE_FIELD_HI       7
`define ROLE_FIELD_LO       6
`define ROLE_SEMI_OPT       3
`define ROLE_WRITE_MASK     8'hC8

// Role field codes.
`define ROLE_STANDALONE     2'h0
`define ROLE_MASTER         2'h1
`define ROLE_SLAVE          2'h2
`define ROLE_SEMI_MASTER    2'h3

// Digital test select codes.
`define DSEL_DESAT          3'h0
`define DSEL_PWM_MONO       3'h1
`define DSEL_PWM_OSC        3'h2
`define DSEL_TIMER_MATCH    3'h3
`define DSEL_OVERVOLT       3'h4
`define DSEL_SW_FREQ        3'h5
`define DSEL_SEC_PULSE      3'h6
`define DSEL_UNUSED         3'h7

// Timing: clock period and secondary drive pulse width.
`define CLK_PERIOD_PS       4000
`define SEC_PULSE_NS        200
`define SEC_PULSE_CYCLES    ((`SEC_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// *** pulse_stretcher.v ***
/*
 * Fixed-width one-shot: a rising edge on the trigger starts a pulse of
 * WIDTH clock cycles. Retriggering during the pulse restarts the width.
 * Assumes the trigger is synchronous to clk_i.
 */
`default_nettype none

module pulse_stretcher #(
    parameter WIDTH = 50,
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Trigger and pulse
    input  wire             trigger_i,
    output reg              pulse_o
);

    reg             trigger_prev;
    reg [CNT_W-1:0] remaining;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trigger_prev <= 1'b0;
            remaining    <= {CNT_W{1'b0}};
            pulse_o      <= 1'b0;
        end
        else
        begin
            trigger_prev <= trigger_i;
            if (trigger_i && !trigger_prev)
            begin
                remaining <= WIDTH[CNT_W-1:0] - 1'b1;
                pulse_o   <= 1'b1;
            end
            else if (remaining != {CNT_W{1'b0}})
            begin
                remaining <= remaining - 1'b1;
            end
            else
            begin
                pulse_o <= 1'b0;
            end
        end
    end

endmodule // pulse_stretcher

`default_nettype wire

// *** regs_asserts.sv ***
/*
 * Port checks for the analog enable and role register bank.
 * Assumes a bind to the bank and its single clock with synchronous reset.
 */
`default_nettype none
module regs_asserts #(
    parameter ADDR_W = 8
) (
    // Clock, reset and bus
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    // Control outputs and trigger
    input wire logic              secondary_drive_on_i,
    input wire logic              current_amp_disable_o,
    input wire logic              voltage_amp_disable_o,
    input wire logic              current_amp_in_loop_o,
    input wire logic              voltage_amp_in_loop_o,
    input wire logic              amp_outputs_pull_low_o,
    input wire logic              ov_protect_enable_o,
    input wire logic              secondary_drive_pulse_o,
    input wire logic              test_output_pin_o,
    input wire logic              test_output_pin_oe_n_o,
    input wire logic              test_pin_analog_connect_o,
    input wire logic              analog_to_converter_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
sequence role_read;
    (taken and (!wb_we_i && wb_adr_i == 'h04)) ##1 wb_ack_o;
endsequence
a_ack_once: assert property (taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after the request");
a_role_zeros: assert property (role_read |-> wb_dat_o[31:8] == 0 && wb_dat_o[5:4] == 0
    && wb_dat_o[2:0] == 0) else $error("unused role bits read nonzero");
a_pull_both: assert property (amp_outputs_pull_low_o ==
    (current_amp_disable_o && voltage_amp_disable_o)) else $error("pull low mismatch");
a_amp_handover: assert property (current_amp_disable_o != voltage_amp_disable_o |->
    current_amp_in_loop_o == voltage_amp_disable_o
    && voltage_amp_in_loop_o == current_amp_disable_o) else $error("loop handover wrong");
a_ov_follows: assert property (ov_protect_enable_o == voltage_amp_disable_o)
    else $error("overvoltage protection not tied to voltage amp disable");
a_digital_wins: assert property (!test_output_pin_oe_n_o |-> !test_pin_analog_connect_o)
    else $error("analog connected while digital drives the test pin");
a_analog_route: assert property (test_pin_analog_connect_o |-> !analog_to_converter_o)
    else $error("analog signals on pin and converter at once");
a_test_pin_idle: assert property (test_output_pin_oe_n_o |-> !test_output_pin_o)
    else $error("test pin value while disconnected");
a_pulse_width: assert property ($rose(secondary_drive_on_i) |->
    ##[1:3] secondary_drive_pulse_o [*8]) else $error("one-shot missing or short");
endmodule // regs_asserts
bind analog_enable_and_mode_regs regs_asserts #(.ADDR_W(ADDR_W)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .secondary_drive_on_i(secondary_drive_on_i), .current_amp_disable_o(current_amp_disable_o),
    .voltage_amp_disable_o(voltage_amp_disable_o), .current_amp_in_loop_o(current_amp_in_loop_o),
    .voltage_amp_in_loop_o(voltage_amp_in_loop_o), .amp_outputs_pull_low_o(amp_outputs_pull_low_o),
    .ov_protect_enable_o(ov_protect_enable_o), .secondary_drive_pulse_o(secondary_drive_pulse_o),
    .test_output_pin_o(test_output_pin_o), .test_output_pin_oe_n_o(test_output_pin_oe_n_o),
    .test_pin_analog_connect_o(test_pin_analog_connect_o),
    .analog_to_converter_o(analog_to_converter_o));
`default_nettype wire

// *** sync_partner.sv ***
/*
 * Far side of the shared sync pin: a master-side clock source and the pull-up.
 * Assumes the design releases the pin whenever this model is told to run.
 */
`default_nettype none
module sync_partner (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic run_i,
    // Design side of the pin
    input  wire logic dut_sync_i,
    input  wire logic dut_sync_oe_n_i,
    // Resolved pin level
    output wire logic line_o
);
timeunit 1ns;
timeprecision 1ps;
logic [1:0] div     = 2'h0;
logic       clk_out = 1'b0;
// The clock stands still while idle so a stray edge never reaches the design.
always @(posedge clk_i)
begin
    div <= div + 2'h1;
    if (run_i && div == 2'h3)
        clk_out <= !clk_out;
end
assign line_o = !dut_sync_oe_n_i ? dut_sync_i : run_i ? clk_out : 1'b1;
endmodule // sync_partner
`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for the analog enable and role register bank.
 * Assumes the sync pin partner model and the checker are compiled alongside.
 */
`default_nettype none
`include "analog_mode_consts.vh"
module testbench;
timeunit 1ns;
timeprecision 1ps;
logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trig = 0, run = 0;
logic [7:0]  adr = 0;
logic [3:0]  sel = 0;
logic [31:0] dat = 0, q, dat_o;
logic [5:0]  src = 0;
logic [2:0]  gp = 0;
logic        ack, lvl, cdis, vdis, cin, vin, pull, ov, pls, pin, oen, acon, tconv;
logic        rpin, rcon, so, soen, swc, line;
integer      mismatches = 0, n_tests = 0, seed = 32'hB72A483F, abe = 0, role = 0, k, c1, c2;
initial forever #2 clk_i = ~clk_i;
analog_enable_and_mode_regs dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .desaturation_comparator_out_i(src[0]), .pwm_after_mono_i(src[1]), .pwm_osc_i(src[2]),
    .timer_period_match_i(src[3]), .overvoltage_comparator_out_i(src[4]),
    .internal_switching_clock_i(src[5]), .secondary_drive_on_i(trig),
    .gp_ref_out_i(gp[0]), .gp_sync_out_i(gp[1]), .gp_sync_oe_n_i(gp[2]),
    .driver_lockout_level_select_o(lvl), .current_amp_disable_o(cdis),
    .voltage_amp_disable_o(vdis), .current_amp_in_loop_o(cin), .voltage_amp_in_loop_o(vin),
    .amp_outputs_pull_low_o(pull), .ov_protect_enable_o(ov), .secondary_drive_pulse_o(pls),
    .test_output_pin_o(pin), .test_output_pin_oe_n_o(oen), .test_pin_analog_connect_o(acon),
    .analog_to_converter_o(tconv), .reference_output_pin_o(rpin),
    .reference_pin_analog_connect_o(rcon), .sync_pin_i(line), .sync_pin_o(so),
    .sync_pin_oe_n_o(soen), .switching_clock_o(swc));
sync_partner partner_u (.clk_i(clk_i), .run_i(run), .dut_sync_i(so),
    .dut_sync_oe_n_i(soen), .line_o(line));
task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask
task automatic complete_run;
    if (mismatches == 0 && n_tests > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    k = 0;
    do
    begin
        @(posedge clk_i);
        k++;
    end
    while (ack !== 1'b1 && k < 20);
    mismatches += (k >= 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
endtask
task automatic cmp;
    logic [1:0] r;
    logic dc, gio, rc;
    logic [7:0] srcv;
    r = role[7:6];
    srcv = {2'b00, src};
    dc = r == 1 || (r == 3 && role[3]);
    gio = r == 0 || (r == 3 && !role[3]);
    rc = r == 1 || (r == 3 && !role[3]);
    check("amps", {lvl, cdis, vdis, cin, vin, pull, ov}, {abe[3], abe[1], abe[2], !abe[1],
        !abe[2], abe[1] & abe[2], abe[2]});
    check("test pin", {pin, oen, acon, tconv}, {abe[7] & srcv[abe[6:4]], !abe[7],
        abe[0] & !abe[7], !abe[0]});
    check("ref pin", {rpin, rcon}, {!rc & gp[0], rc});
    check("sync pin", {soen, so & (r != 2)}, {dc ? 1'b0 : gio ? gp[2] : 1'b1,
        (dc ? src[5] : gp[1]) & (r != 2)});
    check("switching clock", swc, r == 2 ? line : src[5]);
endtask
initial
begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 48; i++)
    begin
        // Cycling select and role codes guarantees every code is visited.
        abe = ($random(seed) & 'h8F) | (i % 8) << 4;
        role = ($random(seed) & 'h3F) | (i % 4) << 6;
        src <= 6'($random(seed)) | {(role[7:6] == 2'h2), 5'h00};
        gp <= 3'($random(seed));
        bus(1, `ABE_OFFSET, {24'($random(seed)), 8'(abe)}, 4'h1);
        bus(1, `ROLE_OFFSET, {24'($random(seed)), 8'(role)}, 4'h1);
        role &= 'hC8;
        repeat (2) @(negedge clk_i);
        cmp;
        bus(0, `ABE_OFFSET, 0, 4'hF);
        check("abe read", abe, q);
        bus(0, `ROLE_OFFSET, 0, 4'hF);
        check("role read", role, q);
    end
    bus(1, `ABE_OFFSET, 32'hFF, 4'h0);
    bus(1, 8'h08, 32'hFF, 4'hF);
    bus(0, 8'h08, 0, 4'hF);
    check("unmapped read", 0, q);
    bus(0, `ABE_OFFSET, 0, 4'hF);
    check("masked write", abe, q);
    bus(1, `ABE_OFFSET, 32'hE0, 4'h1);
    trig <= 1;
    {c1, c2} = 0;
    repeat (70)
    begin
        @(negedge clk_i);
        c1 += pls;
        c2 += pin;
    end
    check("pulse width", 200 / 4, c1);
    check("pulse on test pin", 200 / 4, c2);
    bus(1, `ROLE_OFFSET, 32'h80, 4'h1);
    trig <= 0;
    run <= 1;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 30; i++)
    begin
        c1 = line;
        @(negedge clk_i);
        check("slave clock", c1, swc);
    end
    check("slave release", 1, soen);
    @(posedge clk_i);
    {run, rst_i} <= 2'b01;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `ABE_OFFSET, 0, 4'hF);
    check("abe after reset", 0, q);
    complete_run;
end
// The whole sequence needs about 3 us; the margin covers a slow bus answer.
initial
begin
    #20us;
    mismatches++;
    complete_run;
end
endmodule // testbench
`default_nettype wire
